// File: common/irqpg_pkg.sv
// Summary of operation
// - In Normal or Stop mode an interrupt drives the pin low for one pulse width.
// - The pin stays high at least the gap time between two pulses.
// - Raising a pulse never changes the operating mode.
// - Outside Init mode the pin is push-pull, driving both levels actively.
// - A mask enables each of six status groups; each group ORs its flags.
// - Except on Stop entry, wake flags raise interrupts only when the input is a wake source.
// - Wake sources: bus wake, wake pins, cyclic timers, brake flags when braking enabled.
// - Group path and wake path both active; either can trigger a pulse.
// - Supply undervolt, short, overvolt and stage-two shutdown raise no interrupt.
// - The power-on flag never causes a pulse.
// - Uncleared serial-frame or checksum errors cause periodic repeat pulses.
// - Clearing the periodic enable bit stops repeat pulses.
// - No pulses in Restart, Fail-Safe or Sleep mode.
// - Entering Stop with wake or brake flags still set gives a pulse.
// - Readable status registers update as each pulse starts, one cycle before the pin falls.
// - Event flags stay latched until the host clears them.
// - In Init mode the pin selects software development mode entry.
// - Events together or during a low pulse merge into that pulse.
package irqpg_pkg;
  localparam int NSTAT = 7;
  // status group indices, also register order
  localparam int G_SUP = 0;
  localparam int G_THERM = 1;
  localparam int G_BUS = 2;
  localparam int G_HS = 3;
  localparam int G_BRIDGE = 4;
  localparam int G_DEV = 5;
  localparam int G_WAKE = 6;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WAKE_EN = 8'h04;
  localparam logic [7:0] OFS_STAT0 = 8'h08;
  localparam logic [7:0] OFS_LAST = 8'h20;
  localparam int CTRL_CYC_BIT = 8;
  localparam int CTRL_BRK_BIT = 9;
  localparam int DEV_SEL_BIT = 8;
  localparam logic [9:0] CTRL_RESET = 10'h13F;
  localparam logic [7:0] WAKE_EN_RESET = 8'h00;
  localparam logic [7:0] SUP_IRQ_MASK = 8'hF0;
  localparam logic [7:0] THERM_IRQ_MASK = 8'hFE;
  localparam logic [7:0] DEV_IRQ_MASK = 8'h03;
  localparam logic [7:0] ALL_IRQ_MASK = 8'hFF;
  localparam logic [7:0] BRK_MASK = 8'h0F;
  localparam logic [2:0] MODE_INIT = 3'h0;
  localparam logic [2:0] MODE_NORMAL = 3'h1;
  localparam logic [2:0] MODE_STOP = 3'h2;
  localparam logic [2:0] MODE_SLEEP = 3'h3;
  localparam logic [2:0] MODE_RESTART = 3'h4;
  localparam logic [2:0] MODE_FAILSAFE = 3'h5;
  localparam int IRQ_PULSE_CYC = 16;
  localparam int IRQ_GAP_CYC = 8;
  localparam int IRQ_PERIOD_CYC = 2000;
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_GAP} irqpg_state_t;

  function automatic logic [7:0] irq_mask(input int g);
    case (g)
      G_SUP: irq_mask = SUP_IRQ_MASK;
      G_THERM: irq_mask = THERM_IRQ_MASK;
      G_DEV: irq_mask = DEV_IRQ_MASK;
      default: irq_mask = ALL_IRQ_MASK;
    endcase
  endfunction
endpackage

// File: verilog/irqpg_pulse.sv
`timescale 1ns/1ps
module irqpg_pulse #(
  parameter int PULSE_CYC = irqpg_pkg::IRQ_PULSE_CYC,
  parameter int GAP_CYC = irqpg_pkg::IRQ_GAP_CYC
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic req, // pending pulse request
  output logic start, // pulse accepted, the cycle before low rises
  output logic low // pulse in progress
);
  import irqpg_pkg::*;
  irqpg_state_t state;
  logic [15:0] cnt;
  logic [15:0] low_run;
  logic [15:0] high_run;

  assign start = (state == ST_IDLE) && req;
  assign low = (state == ST_LOW);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cnt <= 16'h0000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (req) begin
            state <= ST_LOW;
            cnt <= 16'h0000;
          end
        end
        ST_LOW: begin
          if (cnt == 16'(PULSE_CYC - 1)) begin
            state <= ST_GAP;
            cnt <= 16'h0000;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        ST_GAP: begin
          if (cnt == 16'(GAP_CYC - 1)) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper counters read only by assertions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_run <= 16'h0000;
      high_run <= 16'hFFFF;
    end else begin
      low_run <= low ? low_run + 16'h0001 : 16'h0000;
      high_run <= low ? 16'h0000 : ((high_run == 16'hFFFF) ? high_run : high_run + 16'h0001);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_pulse_width;
    $fell(low) |-> low_run == 16'(PULSE_CYC);
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");

  property p_gap_min;
    $rose(low) |-> high_run >= 16'(GAP_CYC);
  endproperty
  a_gap_min: assert property (p_gap_min) else $error("gap too short");
endmodule

// File: verilog/irqpg_top.sv
`timescale 1ns/1ps
module irqpg_top #(
  parameter int PULSE_CYC = irqpg_pkg::IRQ_PULSE_CYC,
  parameter int GAP_CYC = irqpg_pkg::IRQ_GAP_CYC,
  parameter int PERIOD_CYC = irqpg_pkg::IRQ_PERIOD_CYC
) (
  input wire logic pclk, // 125 MHz clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [2:0] mode, // device operating mode
  input wire logic [7:0] supply_set, // supply event set pulses
  input wire logic [7:0] thermal_flags_set, // thermal event set pulses
  input wire logic [7:0] bus_set, // bus event set pulses
  input wire logic [7:0] high_side_fault_flags_set, // high-side event set pulses
  input wire logic [7:0] bridge_drain_source_flags_set, // bridge event set pulses
  input wire logic [7:0] device_flags_set, // device event set pulses
  input wire logic [7:0] wake_event_flags_set, // wake event set pulses
  input wire logic irq_n_pin_i, // pin level seen from outside
  output logic irq_n_pin_o, // pin drive value, active low
  output logic irq_n_pin_oe // pin drive enable
);
  import irqpg_pkg::*;

  logic [NSTAT-1:0][7:0] ev;
  logic [NSTAT-1:0][7:0] live;
  logic [NSTAT-1:0][7:0] shown;
  logic [NSTAT-1:0][7:0] new_bits;
  logic [NSTAT-1:0][7:0] clr;
  logic [9:0] ctrl;
  logic [7:0] wake_en;
  logic [2:0] mode_q;
  logic sync1;
  logic sync2;
  logic dev_select;
  logic pend;
  logic start;
  logic pulse_low;
  logic allow;
  logic [5:0] grp_new;
  logic wake_new;
  logic brk_new;
  logic stop_entry;
  logic cyc_pending;
  logic cyc_fire;
  logic [15:0] cyc_cnt;
  logic trig;
  logic ack_go;
  logic wr_commit;
  logic [3:0] wr_idx;
  logic [31:0] rd_data;
  logic rd_hit;

  function automatic logic [3:0] stat_idx(input logic [7:0] a);
    if (a >= OFS_STAT0 && a <= OFS_LAST && a[1:0] == 2'b00) begin
      stat_idx = 4'(3'(a[7:2] - OFS_STAT0[7:2]));
    end else begin
      stat_idx = 4'hF;
    end
  endfunction

  assign ev[G_SUP] = supply_set;
  assign ev[G_THERM] = thermal_flags_set;
  assign ev[G_BUS] = bus_set;
  assign ev[G_HS] = high_side_fault_flags_set;
  assign ev[G_BRIDGE] = bridge_drain_source_flags_set;
  assign ev[G_DEV] = device_flags_set;
  assign ev[G_WAKE] = wake_event_flags_set;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, so data and error come from flops

  assign ack_go = psel && penable && !pready;
  assign wr_commit = psel && penable && pready && pwrite && !pslverr;
  assign wr_idx = stat_idx(paddr);

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr == OFS_CTRL) begin
      rd_data[9:0] = ctrl;
    end else if (paddr == OFS_WAKE_EN) begin
      rd_data[7:0] = wake_en;
    end else if (stat_idx(paddr) != 4'hF) begin
      rd_data[7:0] = shown[stat_idx(paddr)];
      if (stat_idx(paddr) == 4'(G_DEV)) begin
        rd_data[DEV_SEL_BIT] = dev_select;
      end
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= ack_go;
      pslverr <= ack_go && !rd_hit;
      if (ack_go && !pwrite) begin
        prdata <= rd_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      wake_en <= WAKE_EN_RESET;
    end else if (wr_commit) begin
      if (paddr == OFS_CTRL) begin
        ctrl <= pwdata[9:0];
      end
      if (paddr == OFS_WAKE_EN) begin
        wake_en <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status; writing one clears a bit, a same-cycle event wins

  generate
    for (genvar g = 0; g < NSTAT; g++) begin : g_clr
      assign clr[g] = (wr_commit && wr_idx == 4'(g)) ? pwdata[7:0] : 8'h00;
      assign new_bits[g] = ev[g] & ~live[g];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live <= '0;
    end else begin
      for (int g = 0; g < NSTAT; g++) begin
        live[g] <= (live[g] & ~clr[g]) | ev[g];
      end
    end
  end

  // host view is refreshed only when a pulse starts, so a read between
  // pulses sees one coherent picture of what the pulse announced
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shown <= '0;
    end else begin
      for (int g = 0; g < NSTAT; g++) begin
        if (start) begin
          shown[g] <= ((live[g] & ~clr[g]) | ev[g]);
        end else begin
          shown[g] <= shown[g] & ~clr[g];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger sources

  generate
    for (genvar g = 0; g < 6; g++) begin : g_grp
      // excluded restart and power-on bits never reach the OR
      assign grp_new[g] = ctrl[g] && |(new_bits[g] & irq_mask(g));
    end
  endgenerate

  assign wake_new = |(new_bits[G_WAKE] & wake_en);
  assign brk_new = ctrl[CTRL_BRK_BIT] && |(new_bits[G_BRIDGE] & BRK_MASK);

  // mode is only observed here, never driven by this block
  assign allow = (mode == MODE_NORMAL) || (mode == MODE_STOP);
  assign stop_entry = (mode == MODE_STOP) && (mode_q != MODE_STOP) &&
                      ((|live[G_WAKE]) ||
                       (ctrl[CTRL_BRK_BIT] && |(live[G_BRIDGE] & BRK_MASK)));

  assign trig = (|grp_new) || wake_new || brk_new || stop_entry || cyc_fire;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_INIT;
    end else begin
      mode_q <= mode;
    end
  end

  // events seen while pulse_low is set fold into that pulse; events in
  // the gap wait as one request for the next pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 1'b0;
    end else if (!allow) begin
      pend <= 1'b0;
    end else begin
      pend <= (pend && !start) || (trig && !pulse_low && !start);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // periodic repeat while frame or checksum errors stay uncleared

  assign cyc_pending = allow && ctrl[CTRL_CYC_BIT] && |(live[G_DEV] & DEV_IRQ_MASK);
  assign cyc_fire = cyc_pending && (cyc_cnt == 16'(PERIOD_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_cnt <= 16'h0000;
    end else if (!cyc_pending || start || cyc_fire) begin
      cyc_cnt <= 16'h0000;
    end else begin
      cyc_cnt <= cyc_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse timing and pin

  irqpg_pulse #(
    .PULSE_CYC(PULSE_CYC),
    .GAP_CYC(GAP_CYC)
  ) u_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .req(pend && allow),
    .start(start),
    .low(pulse_low)
  );

  // in init the pin is released so the strap level can be read back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n_pin_o <= 1'b1;
      irq_n_pin_oe <= 1'b0;
    end else begin
      irq_n_pin_oe <= (mode != MODE_INIT);
      irq_n_pin_o <= !(pulse_low && allow);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else begin
      sync1 <= irq_n_pin_i;
      sync2 <= sync1;
    end
  end

  // a low pin seen during init asks for development mode entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_select <= 1'b0;
    end else if (mode == MODE_INIT) begin
      dev_select <= !sync2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_quiet_modes;
    !allow |=> irq_n_pin_o;
  endproperty
  a_quiet_modes: assert property (p_quiet_modes) else $error("pulse in quiet mode");

  property p_init_release;
    (mode == MODE_INIT) |=> !irq_n_pin_oe;
  endproperty
  a_init_release: assert property (p_init_release) else $error("pin driven in init");

  property p_push_pull;
    (mode != MODE_INIT) |=> irq_n_pin_oe;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("pin not driven");

  property p_flag_sticks;
    (device_flags_set != 8'h00) |=>
      ((live[G_DEV] & $past(device_flags_set)) == $past(device_flags_set));
  endproperty
  a_flag_sticks: assert property (p_flag_sticks) else $error("event flag lost");

  property p_snapshot;
    start |=> shown[G_DEV] == live[G_DEV];
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("status not captured");

  // the counter may still hold a count on the first edge after the bit drops
  property p_cyc_off;
    !ctrl[CTRL_CYC_BIT] |-> !cyc_fire ##1 (cyc_cnt == 16'h0000);
  endproperty
  a_cyc_off: assert property (p_cyc_off) else $error("repeat while disabled");

  property p_trig_served;
    (trig && allow && !pulse_low && !start) ##1 allow[*1] |->
      ##[0:64] (pulse_low || !allow);
  endproperty
  a_trig_served: assert property (p_trig_served) else $error("trigger lost");

  // a trigger during the low phase must not leave a request behind
  property p_merge;
    pulse_low && trig |=> !pend;
  endproperty
  a_merge: assert property (p_merge) else $error("second pulse while low");

  property p_por_silent;
    (new_bits[G_SUP] != 8'h00) && ((new_bits[G_SUP] & SUP_IRQ_MASK) == 8'h00) |-> !grp_new[G_SUP];
  endproperty
  a_por_silent: assert property (p_por_silent) else $error("supply exception fired");

  property p_pin_falls;
    start && allow ##1 allow |=> !irq_n_pin_o;
  endproperty
  a_pin_falls: assert property (p_pin_falls) else $error("pin did not fall");

  c_wake_pulse: cover property (wake_new && allow ##[1:4] start);
  c_periodic: cover property (cyc_fire ##[1:4] start);
  c_stop_entry: cover property (stop_entry ##[1:4] start);
  c_merge: cover property (pulse_low && trig);
endmodule

// File: verification/irqpg_host.sv
`timescale 1ns/1ps
module irqpg_host (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic pin_o, // device drive value
  input wire logic pin_oe, // device drive enable
  input wire logic pull_low, // host pulls the line low
  output logic pin, // resolved line level
  output logic [15:0] pulse_cnt, // pulses seen
  output logic [7:0] last_width, // low cycles of last pulse
  output logic [7:0] min_gap // shortest high time between pulses
);
  logic prev;
  logic seen;
  logic [7:0] wcnt;
  logic [7:0] gcnt;
  ////////////////////////////////////////////////////////////////////////////////
  // host side has a pull-up, so an undriven line reads high unless pulled low
  assign pin = pin_oe ? pin_o : !pull_low;
  ////////////////////////////////////////////////////////////////////////////////
  // only falls while the device drives count as pulses; init strapping is not one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 1'h1;
      seen <= 1'h0;
      wcnt <= 8'h00;
      gcnt <= 8'h00;
      pulse_cnt <= 16'h0000;
      last_width <= 8'h00;
      min_gap <= 8'hFF;
    end else begin
      prev <= pin;
      if (pin_oe && prev && !pin) begin
        pulse_cnt <= pulse_cnt + 16'h0001;
        wcnt <= 8'h01;
        seen <= 1'h1;
        if (seen && gcnt < min_gap) begin
          min_gap <= gcnt;
        end
      end else if (!pin) begin
        wcnt <= wcnt + 8'h01;
      end
      if (!prev && pin) begin
        last_width <= wcnt;
        gcnt <= 8'h01;
      end else if (pin && gcnt != 8'hFF) begin
        gcnt <= gcnt + 8'h01;
      end
    end
  end
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import irqpg_pkg::*;
  localparam int PW = 4;
  localparam int GW = 3;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pin_o, pin_oe, pin;
  logic pull_low = 1'h0;
  logic [2:0] mode = MODE_NORMAL;
  logic [7:0] sset [0:6] = '{default: 8'h00};
  logic [15:0] pulse_cnt;
  logic [7:0] last_width, min_gap;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int n_checks = 0;

  initial forever #4 pclk = ~pclk;

  // short pulse, gap and period keep the run brief
  irqpg_top #(.PULSE_CYC(PW), .GAP_CYC(GW), .PERIOD_CYC(50)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode(mode), .supply_set(sset[0]), .thermal_flags_set(sset[1]), .bus_set(sset[2]),
    .high_side_fault_flags_set(sset[3]), .bridge_drain_source_flags_set(sset[4]),
    .device_flags_set(sset[5]), .wake_event_flags_set(sset[6]),
    .irq_n_pin_i(pin), .irq_n_pin_o(pin_o), .irq_n_pin_oe(pin_oe));

  irqpg_host host_u (.pclk(pclk), .presetn(presetn), .pin_o(pin_o), .pin_oe(pin_oe),
    .pull_low(pull_low), .pin(pin), .pulse_cnt(pulse_cnt), .last_width(last_width),
    .min_gap(min_gap));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'h1 && i < 64);
    if (pready !== 1'h1) begin
      n_mismatch++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  function automatic logic [7:0] sta(input int g);
    return OFS_STAT0 + 8'(4 * g);
  endfunction

  task automatic strobe(input int g, input logic [7:0] v);
    @(posedge pclk);
    sset[g] <= v;
    @(posedge pclk);
    sset[g] <= 8'h00;
  endtask

  task automatic cnt_chk(input string nm, input int n, input int exp);
    logic [15:0] c0;
    c0 = pulse_cnt;
    repeat (n) @(posedge pclk);
    chk(nm, 32'(pulse_cnt - c0), exp);
  endtask

  task automatic wait_pin(input logic lvl);
    for (int i = 0; i < 100 && pin !== lvl; i++) @(posedge pclk);
    if (pin !== lvl) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdchk("ctrl reset", OFS_CTRL, 32'(CTRL_RESET));
    chk("mapped error", {31'h0, err}, 32'h0);
    rdchk("wake enable reset", OFS_WAKE_EN, 32'(WAKE_EN_RESET));
    apb(1'h0, OFS_LAST + 8'h04, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("drive enable", {31'h0, pin_oe}, 32'h1);
  endtask

  // periodic repeat kept off here so a late repeat cannot land in a window
  task automatic t_groups;
    logic [7:0] a, b, ea;
    for (int g = 0; g < NSTAT; g++) begin
      ea = (g == G_WAKE) ? OFS_WAKE_EN : OFS_CTRL;
      a = (g == G_DEV) ? 8'h01 : 8'h40;
      b = (g == G_DEV) ? 8'h02 : 8'h80;
      wr(ea, (g == G_WAKE) ? 32'h0 : (32'h03F & ~(32'h1 << g)));
      strobe(g, a);
      cnt_chk("masked source", 40, 0);
      wr(sta(g), 32'hFF);
      wr(ea, (g == G_WAKE) ? 32'hFF : 32'h03F);
      strobe(g, b);
      cnt_chk("enabled source", 40, 1);
      chk("pulse width", 32'(last_width), PW);
      rdchk("snapshot", sta(g), 32'(b));
      wr(sta(g), 32'hFF);
      rdchk("cleared", sta(g), 32'h0);
      rdchk("reread", sta(g), 32'h0);
    end
    wr(OFS_WAKE_EN, 32'h0);
    wr(OFS_CTRL, 32'h13F);
  endtask

  task automatic t_excluded;
    strobe(G_SUP, 8'h0F);
    strobe(G_THERM, 8'h01);
    strobe(G_DEV, 8'hFC);
    cnt_chk("excluded flags", 60, 0);
    wr(sta(G_SUP), 32'hFF);
    wr(sta(G_THERM), 32'hFF);
    wr(sta(G_DEV), 32'hFF);
  endtask

  task automatic t_modes;
    logic [2:0] m [3] = '{MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE};
    foreach (m[i]) begin
      @(posedge pclk);
      mode <= m[i];
      strobe(G_BUS, 8'(8'h01 << i));
      cnt_chk("silent mode", 40, 0);
      wr(sta(G_BUS), 32'hFF);
      @(posedge pclk);
      mode <= MODE_NORMAL;
    end
  endtask

  task automatic t_merge;
    logic [15:0] c0;
    c0 = pulse_cnt;
    strobe(G_BUS, 8'h03);
    wait_pin(1'h0);
    strobe(G_BUS, 8'h04);
    wait_pin(1'h1);
    strobe(G_BUS, 8'h08);
    repeat (40) @(posedge pclk);
    chk("merged pulses", 32'(pulse_cnt - c0), 32'h2);
    chk("gap held", {31'h0, min_gap >= GW}, 32'h1);
    rdchk("merged snapshot", sta(G_BUS), 32'h0F);
    cnt_chk("no bus repeat", 150, 0);
    rdchk("still latched", sta(G_BUS), 32'h0F);
    wr(sta(G_BUS), 32'hFF);
  endtask

  task automatic t_periodic;
    logic [15:0] c0;
    c0 = pulse_cnt;
    strobe(G_DEV, 8'h01);
    repeat (200) @(posedge pclk);
    chk("repeat pulses", {31'h0, (pulse_cnt - c0) >= 16'h3}, 32'h1);
    wr(OFS_CTRL, 32'h03F);
    repeat (20) @(posedge pclk);
    cnt_chk("repeat off", 150, 0);
    wr(sta(G_DEV), 32'hFF);
    wr(OFS_CTRL, 32'h13F);
  endtask

  task automatic t_stop;
    strobe(G_WAKE, 8'h01);
    cnt_chk("wake not enabled", 30, 0);
    @(posedge pclk);
    mode <= MODE_STOP;
    cnt_chk("stop entry", 30, 1);
    wr(sta(G_WAKE), 32'hFF);
    @(posedge pclk);
    mode <= MODE_NORMAL;
  endtask

  // bridge group masked so only the brake path can raise the pulse
  task automatic t_brake;
    wr(OFS_CTRL, 32'h22F);
    strobe(G_BRIDGE, 8'h01);
    cnt_chk("brake wake source", 30, 1);
    @(posedge pclk);
    mode <= MODE_STOP;
    cnt_chk("stop entry brake", 30, 1);
    wr(sta(G_BRIDGE), 32'hFF);
    wr(OFS_CTRL, 32'h13F);
    @(posedge pclk);
    mode <= MODE_NORMAL;
  endtask

  task automatic t_init;
    @(posedge pclk);
    mode <= MODE_INIT;
    repeat (3) @(posedge pclk);
    chk("init drive off", {31'h0, pin_oe}, 32'h0);
    pull_low <= 1'h1;
    repeat (6) @(posedge pclk);
    apb(1'h0, sta(G_DEV), 32'h0);
    chk("dev select", {31'h0, rd[DEV_SEL_BIT]}, 32'h1);
    pull_low <= 1'h0;
    @(posedge pclk);
    mode <= MODE_NORMAL;
    repeat (3) @(posedge pclk);
    chk("driven high", {30'h0, pin_oe, pin_o}, 32'h3);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_groups();
    t_excluded();
    t_modes();
    t_merge();
    t_periodic();
    t_stop();
    t_brake();
    t_init();
    tally_and_finish();
  end
endmodule
